// ### hw/slsr_core.sv
// Link sync request handling and sysref alignment
`timescale 1ns/100ps
`include "slsr_cfg.svh"
module slsr_core
    import slsr_pkg::*;
#(
    parameter int LMFC_PERIOD = 32,
    parameter int ILAS_CYCLES = 64
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic single_ended_link_sync_n,
    input wire logic alternate_link_sync_n,
    input wire logic timestamp_input_pair,
    input wire logic sysref_in,
    input wire logic [1:0] sync_sel,
    input wire logic mode_64b66b,
    input wire logic link_enable,
    input wire logic sysref_receiver_enable_cfg,
    output logic sysref_receiver_enable,
    output slsr_link_t link_out,
    output logic [7:0] lmfc_count,
    output logic lmfc_edge,
    output logic [1:0] link_state
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (LMFC_PERIOD < 2 || LMFC_PERIOD > 256)
    begin : g_bad_lmfc
        $error("LMFC_PERIOD out of range");
    end
    if (ILAS_CYCLES < 1 || ILAS_CYCLES > 65535)
    begin : g_bad_ilas
        $error("ILAS_CYCLES out of range");
    end

    localparam logic [7:0] LMFC_LAST = 8'(LMFC_PERIOD - 1);
    localparam logic [15:0] ILAS_LAST = 16'(ILAS_CYCLES - 1);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [3:0] raw_in;
    logic [3:0] sync_in;
    assign raw_in = {sysref_in, timestamp_input_pair, alternate_link_sync_n,
        single_ended_link_sync_n};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            slsr_sync3 u_sync
            (
                .mclk(mclk),
                .rst(rst),
                // Sysref idles low; a high preset would fake an edge after reset
                .rst_val(gi != 3),
                .din(raw_in[gi]),
                .dout(sync_in[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Sync source selection
    // ------------------------------------------------------------
    logic sync_n;
    always_comb
    begin
        case (sync_sel)
            `SLSR_SEL_SINGLE: sync_n = sync_in[0];
            `SLSR_SEL_TIMESTAMP: sync_n = sync_in[2];
            `SLSR_SEL_ALTERNATE: sync_n = sync_in[1];
            default: sync_n = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Sysref alignment of the local multiframe counter
    // ------------------------------------------------------------
    logic sysref_d;
    logic next_sysref_d;
    logic [7:0] next_lmfc_count;
    logic next_lmfc_edge;
    logic sysref_rise;

    // Receiver gated off means sysref is simply ignored
    assign sysref_receiver_enable = sysref_receiver_enable_cfg;
    assign sysref_rise = sysref_receiver_enable && sync_in[3] && !sysref_d;

    always_comb
    begin
        next_sysref_d = sync_in[3];
        if (sysref_rise || lmfc_count == LMFC_LAST)
            next_lmfc_count = `SLSR_LMFC_RST;
        else
            next_lmfc_count = lmfc_count + 8'h01;
        next_lmfc_edge = (next_lmfc_count == `SLSR_LMFC_RST);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sysref_d <= 1'b0;
            lmfc_count <= `SLSR_LMFC_RST;
            lmfc_edge <= 1'b0;
        end
        else
        begin
            sysref_d <= next_sysref_d;
            lmfc_count <= next_lmfc_count;
            lmfc_edge <= next_lmfc_edge;
        end
    end

    // ------------------------------------------------------------
    // Link initialisation state machine
    // ------------------------------------------------------------
    slsr_state_t state;
    slsr_state_t next_state;
    logic [15:0] ilas_cnt;
    logic [15:0] next_ilas_cnt;
    logic ilas_armed;
    logic next_ilas_armed;

    always_comb
    begin
        next_state = state;
        next_ilas_cnt = ilas_cnt;
        next_ilas_armed = ilas_armed;
        if (!link_enable)
        begin
            next_state = SLSR_IDLE;
            // A stale arm would skip the release handshake next time
            next_ilas_armed = 1'b0;
        end
        else if (mode_64b66b)
        begin
            // No handshake at all in this encoding
            next_state = SLSR_DATA;
            next_ilas_armed = 1'b0;
        end
        else
        begin
            case (state)
                SLSR_IDLE:
                begin
                    if (!sync_n)
                        next_state = SLSR_CGS;
                end
                SLSR_CGS:
                begin
                    // Alignment waits for a multiframe boundary after release
                    if (sync_n)
                        next_ilas_armed = 1'b1;
                    if (ilas_armed && sync_n && lmfc_edge)
                    begin
                        next_state = SLSR_ILAS;
                        next_ilas_cnt = 16'h0000;
                        next_ilas_armed = 1'b0;
                    end
                    if (!sync_n)
                        next_ilas_armed = 1'b0;
                end
                SLSR_ILAS:
                begin
                    if (!sync_n)
                        next_state = SLSR_CGS;
                    else if (ilas_cnt == ILAS_LAST)
                        next_state = SLSR_DATA;
                    else
                        next_ilas_cnt = ilas_cnt + 16'h0001;
                end
                SLSR_DATA:
                begin
                    if (!sync_n)
                        next_state = SLSR_CGS;
                end
                default: next_state = SLSR_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state <= SLSR_IDLE;
            ilas_cnt <= 16'h0000;
            ilas_armed <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ilas_cnt <= next_ilas_cnt;
            ilas_armed <= next_ilas_armed;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    slsr_link_t next_link;
    always_comb
    begin
        next_link.cgs = (next_state == SLSR_CGS);
        next_link.ilas = (next_state == SLSR_ILAS);
        next_link.data = (next_state == SLSR_DATA);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            link_out <= '0;
        else
            link_out <= next_link;
    end

    assign link_state = state;
endmodule

// ### hw/slsr_cfg.svh
// Constants for the serial link sync request block
// Notes on behaviour
// - Single-ended sync pin used only when select is zero
// - 64b/66b ignores every sync request input
// - Selected sync low starts code group sync
// - Sync release high starts lane alignment sequence
// - Sysref aligns internal link timing
// - Sysref receiver can be powered down
// - Timestamp pair is alternate sync in 8b/10b
`ifndef SLSR_CFG_SVH
`define SLSR_CFG_SVH
`define SLSR_SEL_SINGLE 2'h0
`define SLSR_SEL_TIMESTAMP 2'h1
`define SLSR_SEL_ALTERNATE 2'h2
`define SLSR_SYNC_STAGES 3
`define SLSR_LMFC_RST 8'h00
`endif

// ### hw/slsr_pkg.sv
// Types for the serial link sync request block
package slsr_pkg;
    typedef enum logic [1:0]
    {
        SLSR_IDLE = 2'b00,
        SLSR_CGS = 2'b01,
        SLSR_ILAS = 2'b10,
        SLSR_DATA = 2'b11
    } slsr_state_t;

    typedef struct packed
    {
        logic cgs;
        logic ilas;
        logic data;
    } slsr_link_t;
endpackage

// ### hw/slsr_sync3.sv
// Three-stage synchroniser for one asynchronous pin
`timescale 1ns/100ps
module slsr_sync3
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic rst_val,
    input wire logic din,
    output logic dout
);
    logic [2:0] pipe;
    logic [2:0] next_pipe;
    logic next_dout;

    always_comb
    begin
        next_pipe = {pipe[1:0], din};
        // Change counts only when stages two and three agree
        next_dout = (pipe[1] == pipe[2]) ? pipe[2] : dout;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pipe <= {3{rst_val}};
            dout <= rst_val;
        end
        else
        begin
            pipe <= next_pipe;
            dout <= next_dout;
        end
    end
endmodule

// ### test/slsr_core_sva.sv
// Checker for the link sync request core
`timescale 1ns/100ps
module slsr_core_sva
    import slsr_pkg::*;
#(
    parameter int LMFC_PERIOD = 32,
    parameter int ILAS_CYCLES = 64
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic single_ended_link_sync_n,
    input wire logic alternate_link_sync_n,
    input wire logic timestamp_input_pair,
    input wire logic sysref_in,
    input wire logic [1:0] sync_sel,
    input wire logic mode_64b66b,
    input wire logic link_enable,
    input wire logic sysref_receiver_enable_cfg,
    input wire logic sysref_receiver_enable,
    input wire slsr_link_t link_out,
    input wire logic [7:0] lmfc_count,
    input wire logic lmfc_edge,
    input wire logic [1:0] link_state
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic sel_n;
    assign sel_n = sync_sel == 2'h0 ? single_ended_link_sync_n :
        sync_sel == 2'h1 ? timestamp_input_pair :
        sync_sel == 2'h2 ? alternate_link_sync_n : 1'b1;
    // Six samples covers the four-flop filter (three stages plus output) plus the state flop
    sequence held_low;
        (link_enable && !mode_64b66b && !sel_n) [*6];
    endsequence
    sequence cgs_to_ilas;
        (link_state == SLSR_CGS) ##1 (link_state == SLSR_ILAS);
    endsequence
    cgs_entry_a: assert property (held_low |-> link_state == SLSR_CGS)
        else $error("sync low did not start cgs");
    m64_ignore_a: assert property ($rose(link_state == SLSR_CGS) |-> !$past(mode_64b66b))
        else $error("cgs entered in 64b66b mode");
    ilas_start_a: assert property (cgs_to_ilas |-> $past(lmfc_edge) || $past(lmfc_edge, 2))
        else $error("ilas not on multiframe edge");
    rst_clear_a: assert property (disable iff (1'b0) rst |=> link_state == SLSR_IDLE && link_out == 3'h0)
        else $error("reset did not clear link");
    en_idle_a: assert property (!link_enable [*2] |-> link_state == SLSR_IDLE)
        else $error("disabled link not idle");
    out_match_a: assert property (link_out == {link_state == SLSR_CGS,
        link_state == SLSR_ILAS, link_state == SLSR_DATA})
        else $error("link flags disagree with state");
    lmfc_range_a: assert property (lmfc_count < LMFC_PERIOD)
        else $error("multiframe count out of range");
    lmfc_pulse_a: assert property (lmfc_edge |=> !lmfc_edge)
        else $error("multiframe edge longer than one cycle");
    sre_copy_a: assert property (sysref_receiver_enable == sysref_receiver_enable_cfg)
        else $error("receiver enable not following setting");
endmodule
bind slsr_core slsr_core_sva #(.LMFC_PERIOD(LMFC_PERIOD), .ILAS_CYCLES(ILAS_CYCLES)) chk
(
    .mclk(mclk),
    .rst(rst),
    .single_ended_link_sync_n(single_ended_link_sync_n),
    .alternate_link_sync_n(alternate_link_sync_n),
    .timestamp_input_pair(timestamp_input_pair),
    .sysref_in(sysref_in),
    .sync_sel(sync_sel),
    .mode_64b66b(mode_64b66b),
    .link_enable(link_enable),
    .sysref_receiver_enable_cfg(sysref_receiver_enable_cfg),
    .sysref_receiver_enable(sysref_receiver_enable),
    .link_out(link_out),
    .lmfc_count(lmfc_count),
    .lmfc_edge(lmfc_edge),
    .link_state(link_state)
);

// ### test/slsr_rx_model.sv
// Far-end receiver: requests sync until it has seen enough cgs
`timescale 1ns/100ps
module slsr_rx_model
(
    input wire logic mclk,
    input wire logic want_sync,
    input wire logic cgs_seen,
    output logic sync_n
);
    int n = 0;
    logic done = 1'b0;
    initial sync_n = 1'b1;
    always @(posedge mclk)
    begin
        n <= cgs_seen ? n + 1 : 0;
        done <= want_sync && (done || n >= 8);
        sync_n <= #1 !(want_sync && !done);
    end
endmodule

// ### test/tb_top.sv
// Testbench for the link sync request core
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_top;
    import slsr_pkg::*;
    logic mclk = 0, rst = 1, want = 0, timestamp_input_pair = 1, alternate_link_sync_n = 1;
    logic sysref_in = 0, mode_64b66b = 0, link_enable = 1, sysref_receiver_enable_cfg = 1;
    logic [1:0] sync_sel = 2'h0;
    logic single_ended_link_sync_n, sysref_receiver_enable, lmfc_edge;
    slsr_link_t link_out;
    logic [7:0] lmfc_count;
    logic [1:0] link_state;
    logic f;
    int bad_count = 0;
    int total_checks = 0;
    initial forever #20 mclk = ~mclk;
    slsr_rx_model rx (.mclk(mclk), .want_sync(want), .cgs_seen(link_out.cgs),
        .sync_n(single_ended_link_sync_n));
    // Short counts keep the run brief
    slsr_core #(.LMFC_PERIOD(16), .ILAS_CYCLES(4)) dut
    (
        .mclk(mclk),
        .rst(rst),
        .single_ended_link_sync_n(single_ended_link_sync_n),
        .alternate_link_sync_n(alternate_link_sync_n),
        .timestamp_input_pair(timestamp_input_pair),
        .sysref_in(sysref_in),
        .sync_sel(sync_sel),
        .mode_64b66b(mode_64b66b),
        .link_enable(link_enable),
        .sysref_receiver_enable_cfg(sysref_receiver_enable_cfg),
        .sysref_receiver_enable(sysref_receiver_enable),
        .link_out(link_out),
        .lmfc_count(lmfc_count),
        .lmfc_edge(lmfc_edge),
        .link_state(link_state)
    );
    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wst(input logic [1:0] s);
        for (int i = 0; i < 200 && link_state !== s; i++) step(1);
        `CHK(link_state, s)
    endtask
    task relink;
        link_enable = 0;
        step(2);
        `CHK(link_state, SLSR_IDLE)
        link_enable = 1;
    endtask
    task t_base;
        want = 1;
        wst(SLSR_CGS);
        `CHK(link_out, 3'h4)
        wst(SLSR_ILAS);
        wst(SLSR_DATA);
        want = 0;
        step(2);
        want = 1;
        wst(SLSR_CGS);
        want = 0;
        wst(SLSR_DATA);
    endtask
    task t_alt;
        relink();
        // Select three reads released whatever the pins do
        sync_sel = 2'h3;
        want = 1;
        timestamp_input_pair = 0;
        alternate_link_sync_n = 0;
        step(10);
        `CHK(link_state, SLSR_IDLE)
        timestamp_input_pair = 1;
        alternate_link_sync_n = 1;
        step(5);
        sync_sel = 2'h1;
        step(10);
        `CHK(link_state, SLSR_IDLE)
        timestamp_input_pair = 0;
        step(7);
        `CHK(link_state, SLSR_CGS)
        timestamp_input_pair = 1;
        relink();
        sync_sel = 2'h2;
        alternate_link_sync_n = 0;
        step(1);
        alternate_link_sync_n = 1;
        step(10);
        `CHK(link_state, SLSR_IDLE)
        alternate_link_sync_n = 0;
        step(7);
        `CHK(link_state, SLSR_CGS)
        alternate_link_sync_n = 1;
        want = 0;
        sync_sel = 2'h0;
    endtask
    task t_64b;
        relink();
        mode_64b66b = 1;
        want = 1;
        wst(SLSR_DATA);
        step(8);
        `CHK(link_out, 3'h1)
        rst = 1;
        step(2);
        `CHK(link_out, 3'h0)
        rst = 0;
        step(2);
        `CHK(link_out, 3'h1)
        mode_64b66b = 0;
        want = 0;
    endtask
    task probe;
        for (int i = 0; i < 40 && lmfc_count !== 8'h01; i++) step(1);
        sysref_in = 1;
        f = 0;
        for (int i = 0; i < 8; i++)
        begin
            step(1);
            if (lmfc_count === 8'h00)
            begin
                f = 1;
                `CHK(lmfc_edge, 1'b1)
            end
        end
        sysref_in = 0;
    endtask
    task t_sysref;
        probe();
        `CHK(f, 1'b1)
        sysref_receiver_enable_cfg = 0;
        step(1);
        `CHK(sysref_receiver_enable, 1'b0)
        probe();
        `CHK(f, 1'b0)
        sysref_receiver_enable_cfg = 1;
    endtask
    task final_report;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        bad_count++;
        final_report();
    end
    initial
    begin
        step(2);
        rst = 0;
        step(3);
        `CHK(lmfc_count, 8'h03)
        t_base();
        t_alt();
        t_64b();
        t_sysref();
        final_report();
    end
endmodule
